/* File: inc/dtc_pkg.sv */
`default_nettype none
// ****************************************************************
// Termination control constants
// ****************************************************************
package dtc_pkg;

  // Register port geometry
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;

  // Register offsets
  localparam logic [7:0]  CFG_ADDR         = 8'h00;
  localparam logic [7:0]  STAT_ADDR        = 8'h04;
  localparam logic [7:0]  LAT_ADDR         = 8'h08;

  // Config register field positions
  localparam int          CFG_TERM_LSB     = 0;
  localparam int          CFG_WLVL_BIT     = 4;
  localparam int          CFG_BL32_BIT     = 5;
  localparam int          CFG_BIN_LSB      = 6;
  localparam int          CFG_WLSET_BIT    = 9;
  localparam logic [31:0] CFG_RESET        = 32'h0000_0000;

  // Status and latency readback field positions
  localparam int          STAT_BUSY_BIT    = 0;
  localparam int          STAT_LINK_LSB    = 1;
  localparam int          LAT_ON_LSB       = 0;
  localparam int          LAT_OFF_LSB      = 8;

  // Extra turn-off cycles for a burst of 32
  localparam logic [5:0]  BL32_EXTRA       = 6'h08;

  // Latencies in memory clocks per frequency bin 7..0, zero means not allowed
  localparam logic [7:0][5:0] ON_SET_A  = {6'h08, 6'h06, 6'h06, 6'h04,
                                           6'h04, 6'h00, 6'h00, 6'h00};
  localparam logic [7:0][5:0] ON_SET_B  = {6'h18, 6'h14, 6'h12, 6'h0E,
                                           6'h0C, 6'h06, 6'h00, 6'h00};
  localparam logic [7:0][5:0] OFF_SET_A = {6'h1C, 6'h1A, 6'h18, 6'h16,
                                           6'h14, 6'h00, 6'h00, 6'h00};
  localparam logic [7:0][5:0] OFF_SET_B = {6'h2C, 6'h28, 6'h24, 6'h20,
                                           6'h1C, 6'h16, 6'h00, 6'h00};

  // Termination strength in ohms per code 7..0, zero means none
  localparam logic [7:0][7:0] OHM_TABLE = {8'h00, 8'h28, 8'h30, 8'h3C,
                                           8'h50, 8'h78, 8'hF0, 8'h00};

  // Word carried to the memory clock side
  typedef struct packed {
    logic [3:0] term;     // Termination config field
    logic       wlvl;     // Write leveling mode
    logic       lat_ok;   // Bin supports termination
    logic [5:0] on_lat;   // Turn-on latency
    logic [5:0] off_lat;  // Turn-off latency, burst adjusted
  } dtc_link_cfg_t;

  localparam int          LINK_CFG_W       = $bits(dtc_link_cfg_t);

  // Write burst sequencer states, Gray along idle, wait, terminate
  typedef enum logic [1:0] {
    DTC_IDLE    = 2'b00,
    DTC_WAIT_ON = 2'b01,
    DTC_TERM    = 2'b11
  } dtc_seq_t;

endpackage
`default_nettype wire

/* File: inc/dtc_sync_if.sv */
`default_nettype none
// ****************************************************************
// Word crossing carrier
// ****************************************************************
interface dtc_sync_if #(parameter int W = 8);
  logic [W-1:0] src_data;   // Word offered on the source side
  logic         src_load;   // Offer strobe, source clock
  logic         src_busy;   // Crossing still in flight
  logic [W-1:0] dst_data;   // Word held on the destination side
  logic         dst_new;    // One-cycle pulse on arrival

  // Crossing logic side
  modport xfer (input src_data, input src_load, output src_busy,
                output dst_data, output dst_new);
  // User side
  modport user (output src_data, output src_load, input src_busy,
                input dst_data, input dst_new);
endinterface
`default_nettype wire

/* File: hw/dtc_word_sync.sv */
`default_nettype none
// ****************************************************************
// Toggle handshake word crossing
// ****************************************************************
module dtc_word_sync #(
  parameter int W = 8
) (
  input  wire logic i_src_clk,
  input  wire logic i_src_rst,
  input  wire logic i_dst_clk,
  input  wire logic i_dst_rst,
  dtc_sync_if.xfer  xf
);

  // Source side state
  typedef struct packed {
    logic [W-1:0] data;     // Held word, stable while busy
    logic         req;      // Request toggle
    logic         ack_s1;   // Ack synchroniser, first stage
    logic         ack_s2;   // Ack synchroniser, second stage
  } dtc_src_t;

  // Destination side state
  typedef struct packed {
    logic         req_s1;   // Request synchroniser, first stage
    logic         req_s2;   // Request synchroniser, second stage
    logic         ack;      // Ack toggle returned to source
    logic [W-1:0] data;     // Captured word
    logic         fresh;    // Arrival pulse
  } dtc_dst_t;

  dtc_src_t s_reg;          // Source registers
  dtc_src_t s_next;         // Source next value
  dtc_dst_t d_reg;          // Destination registers
  dtc_dst_t d_next;         // Destination next value

  // Busy until the ack toggle comes home
  assign xf.src_busy = s_reg.req ^ s_reg.ack_s2;
  assign xf.dst_data = d_reg.data;
  assign xf.dst_new  = d_reg.fresh;

  // Source next state
  always_comb begin
    s_next        = s_reg;
    s_next.ack_s1 = d_reg.ack;
    s_next.ack_s2 = s_reg.ack_s1;
    // A load while busy is dropped so the held word never moves mid-flight
    if (xf.src_load && !xf.src_busy) begin
      s_next.data = xf.src_data;
      s_next.req  = ~s_reg.req;
    end
  end

  // Source registers
  always_ff @(posedge i_src_clk or posedge i_src_rst) begin
    if (i_src_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Destination next state
  always_comb begin
    d_next        = d_reg;
    d_next.req_s1 = s_reg.req;
    d_next.req_s2 = d_reg.req_s1;
    d_next.ack    = d_reg.req_s2;
    d_next.fresh  = d_reg.req_s2 ^ d_reg.ack;
    // Held word is quiet here, the toggle has settled through two stages
    if (d_reg.req_s2 ^ d_reg.ack) begin
      d_next.data = s_reg.data;
    end
  end

  // Destination registers
  always_ff @(posedge i_dst_clk or posedge i_dst_rst) begin
    if (i_dst_rst) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end

endmodule
`default_nettype wire

/* File: hw/dtc_top.sv */
// Implementation choices: the register offsets and the address-and-strobe port.
`default_nettype none
// ****************************************************************
// Data path termination control
// ****************************************************************

module dtc_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_mem_clk,
  input  wire logic        i_wr_cmd,
  input  wire logic        i_cas2_cmd,
  input  wire logic        i_pwr_down,
  output logic             o_dq_term_en,
  output logic             o_dmi_term_en,
  output logic             o_dqs_t_term_en,
  output logic             o_dqs_c_term_en,
  output logic      [7:0]  o_term_resistance_ohm
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Latency lookup and burst adjustment, shared by transfer and readback
  function automatic dtc_pkg::dtc_link_cfg_t build_link_cfg(
    input logic [3:0] term,
    input logic       wlvl,
    input logic       bl32,
    input logic [2:0] bin,
    input logic       wlset
  );
    logic [5:0]             on_l;
    logic [5:0]             off_l;
    dtc_pkg::dtc_link_cfg_t c;
    on_l     = wlset ? dtc_pkg::ON_SET_B[bin] : dtc_pkg::ON_SET_A[bin];
    off_l    = wlset ? dtc_pkg::OFF_SET_B[bin] : dtc_pkg::OFF_SET_A[bin];
    c.term   = term;
    c.wlvl   = wlvl;
    c.lat_ok = (on_l != 6'h00);
    c.on_lat = on_l;
    c.off_lat = bl32 ? (off_l + dtc_pkg::BL32_EXTRA) : off_l;
    return c;
  endfunction

  // ****************************************************************
  // System clock side: register port
  // ****************************************************************

  // All system side state
  typedef struct packed {
    logic [3:0]  term;      // Termination config field
    logic        wlvl;      // Write leveling mode
    logic        bl32;      // Burst of 32 selected
    logic [2:0]  bin;       // Frequency bin
    logic        wlset;     // Write latency set B
    logic [31:0] rdata;     // Read data, valid one cycle after strobe
    logic [3:0]  st_s1;     // Link status synchroniser, first stage
    logic [3:0]  st_s2;     // Link status synchroniser, second stage
  } dtc_sys_t;

  dtc_sys_t                 sys_reg;    // System registers
  dtc_sys_t                 sys_next;   // System next value
  dtc_pkg::dtc_link_cfg_t   sys_lat;    // Stored config in link form
  dtc_pkg::dtc_link_cfg_t   wr_lat;     // Config being written
  logic                     cfg_hit;    // Write to the config register
  logic                     link_rst;   // Reset in the memory clock domain
  logic [1:0]               lrst_sync;  // Reset release synchroniser
  logic [3:0]               link_stat;  // Link status levels to cross

  // Config crossing to the memory clock
  dtc_sync_if #(.W(dtc_pkg::LINK_CFG_W)) xf ();

  dtc_word_sync #(
    .W         (dtc_pkg::LINK_CFG_W)
  ) u_cfg_sync (
    .i_src_clk (i_sys_clk),
    .i_src_rst (i_rst),
    .i_dst_clk (i_mem_clk),
    .i_dst_rst (link_rst),
    .xf        (xf.xfer)
  );

  // Write decode; a write while the crossing is busy is dropped whole
  assign cfg_hit     = i_wr && (i_addr == dtc_pkg::CFG_ADDR) && !xf.src_busy;
  assign wr_lat      = build_link_cfg(i_wdata[dtc_pkg::CFG_TERM_LSB +: 4],
                                      i_wdata[dtc_pkg::CFG_WLVL_BIT],
                                      i_wdata[dtc_pkg::CFG_BL32_BIT],
                                      i_wdata[dtc_pkg::CFG_BIN_LSB +: 3],
                                      i_wdata[dtc_pkg::CFG_WLSET_BIT]);
  assign sys_lat     = build_link_cfg(sys_reg.term, sys_reg.wlvl, sys_reg.bl32,
                                      sys_reg.bin, sys_reg.wlset);
  assign xf.src_data = wr_lat;
  assign xf.src_load = cfg_hit;
  assign o_rdata     = sys_reg.rdata;

  // System next state: config store, readback, status capture
  always_comb begin
    sys_next       = sys_reg;
    sys_next.st_s1 = link_stat;
    sys_next.st_s2 = sys_reg.st_s1;
    sys_next.rdata = '0;
    // Config store mirrors what was sent across
    if (cfg_hit) begin
      sys_next.term  = i_wdata[dtc_pkg::CFG_TERM_LSB +: 4];
      sys_next.wlvl  = i_wdata[dtc_pkg::CFG_WLVL_BIT];
      sys_next.bl32  = i_wdata[dtc_pkg::CFG_BL32_BIT];
      sys_next.bin   = i_wdata[dtc_pkg::CFG_BIN_LSB +: 3];
      sys_next.wlset = i_wdata[dtc_pkg::CFG_WLSET_BIT];
    end
    // Read answer; unmapped offsets read zero
    if (i_rd) begin
      case (i_addr)
        dtc_pkg::CFG_ADDR: begin
          sys_next.rdata[dtc_pkg::CFG_TERM_LSB +: 4] = sys_reg.term;
          sys_next.rdata[dtc_pkg::CFG_WLVL_BIT]      = sys_reg.wlvl;
          sys_next.rdata[dtc_pkg::CFG_BL32_BIT]      = sys_reg.bl32;
          sys_next.rdata[dtc_pkg::CFG_BIN_LSB +: 3]  = sys_reg.bin;
          sys_next.rdata[dtc_pkg::CFG_WLSET_BIT]     = sys_reg.wlset;
        end
        dtc_pkg::STAT_ADDR: begin
          sys_next.rdata[dtc_pkg::STAT_BUSY_BIT]      = xf.src_busy;
          sys_next.rdata[dtc_pkg::STAT_LINK_LSB +: 4] = sys_reg.st_s2;
        end
        dtc_pkg::LAT_ADDR: begin
          sys_next.rdata[dtc_pkg::LAT_ON_LSB +: 6]  = sys_lat.on_lat;
          sys_next.rdata[dtc_pkg::LAT_OFF_LSB +: 6] = sys_lat.off_lat;
        end
        default: begin
          sys_next.rdata = '0;
        end
      endcase
    end
  end

  // System registers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sys_reg      <= '0;
      sys_reg.term <= dtc_pkg::CFG_RESET[dtc_pkg::CFG_TERM_LSB +: 4];
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ****************************************************************
  // Memory clock side: write burst sequencer
  // ****************************************************************

  // Reset release retimed so the sequencer leaves reset on a clean edge
  always_ff @(posedge i_mem_clk or posedge i_rst) begin
    if (i_rst) begin
      lrst_sync <= 2'b11;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b0};
    end
  end
  assign link_rst = lrst_sync[1];

  // All link side state
  typedef struct packed {
    dtc_pkg::dtc_seq_t seq;      // Sequencer state
    logic [5:0]        cnt;      // Cycles since latest second half
    logic              pend;     // Write first half seen
    logic              armed;    // Sequencer busy, for status
    logic              dq_term;  // Data and mask termination
    logic              dqs_term; // Strobe termination
    logic [7:0]        ohm;      // Selected strength
  } dtc_link_t;

  dtc_link_t              l_reg;   // Link registers
  dtc_link_t              l_next;  // Link next value
  dtc_pkg::dtc_link_cfg_t lcfg;    // Config as seen on the link side
  logic                   en;      // Termination enabled
  logic                   live;    // Writes may switch termination
  logic                   start;   // Second half of a write sampled

  assign lcfg  = xf.dst_data;
  assign en    = (lcfg.term != 4'h0);
  assign live  = en && lcfg.lat_ok && !lcfg.wlvl && !i_pwr_down;
  assign start = i_cas2_cmd && (l_reg.pend || i_wr_cmd);

  assign link_stat = {lcfg.lat_ok, l_reg.armed, l_reg.dqs_term, l_reg.dq_term};

  // Link next state
  always_comb begin
    l_next = l_reg;
    // Pending first half; the second half consumes it
    if (i_cas2_cmd) begin
      l_next.pend = 1'b0;
    end else if (i_wr_cmd) begin
      l_next.pend = 1'b1;
    end
    // count memory clocks after the second half
    if (l_reg.seq != dtc_pkg::DTC_IDLE) begin
      l_next.cnt = l_reg.cnt + 6'h01;
    end
    // off by default, on and off around the burst
    case (l_reg.seq)
      dtc_pkg::DTC_IDLE: begin
        if (start && live) begin
          l_next.seq = dtc_pkg::DTC_WAIT_ON;
          l_next.cnt = 6'h01;
        end
      end
      dtc_pkg::DTC_WAIT_ON: begin
        // A newer write restarts the count
        if (start) begin
          l_next.cnt = 6'h01;
        end else if (l_reg.cnt == lcfg.on_lat) begin
          l_next.seq = dtc_pkg::DTC_TERM;
        end
      end
      dtc_pkg::DTC_TERM: begin
        // Back to back bursts keep termination on; off follows the newest
        if (start) begin
          l_next.cnt = 6'h01;
        end else if (l_reg.cnt == lcfg.off_lat) begin
          l_next.seq = dtc_pkg::DTC_IDLE;
        end
      end
      default: begin
        l_next.seq = dtc_pkg::DTC_IDLE;
      end
    endcase
    // power-down, leveling or disable abort the burst
    if (!live) begin
      l_next.seq  = dtc_pkg::DTC_IDLE;
      l_next.pend = 1'b0;
    end
    l_next.armed   = (l_next.seq != dtc_pkg::DTC_IDLE);
    // leveling never reaches the terminate state
    l_next.dq_term = (l_next.seq == dtc_pkg::DTC_TERM);
    // leveling with termination disabled gives none
    if (lcfg.wlvl) begin
      l_next.dqs_term = en && !i_pwr_down;
    end else begin
      l_next.dqs_term = l_next.dq_term;
    end
    // strength from the low three bits
    l_next.ohm = dtc_pkg::OHM_TABLE[lcfg.term[2:0]];
  end

  // Link registers
  always_ff @(posedge i_mem_clk or posedge link_rst) begin
    if (link_rst) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // dq_term drives the data and mask pins, dqs_term drives both strobe pins
  assign o_dq_term_en          = l_reg.dq_term;
  assign o_dmi_term_en         = l_reg.dq_term;
  assign o_dqs_t_term_en       = l_reg.dqs_term;
  assign o_dqs_c_term_en       = l_reg.dqs_term;
  assign o_term_resistance_ohm = l_reg.ohm;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Write whose second half arrives while termination may switch
  sequence s_live_start;
    (l_reg.seq == dtc_pkg::DTC_IDLE) && start && live;
  endsequence

  // Config word unchanged over the next cycle
  sequence s_cfg_held;
    ##1 $stable(xf.dst_data);
  endsequence

  a_turn_on_time: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    $rose(o_dq_term_en) |-> (l_reg.cnt == lcfg.on_lat + 6'h01))
    else $error("termination rose at the wrong count");

  a_first_half_only: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    (l_reg.seq == dtc_pkg::DTC_IDLE) && i_wr_cmd && !i_cas2_cmd
    |=> (l_reg.seq == dtc_pkg::DTC_IDLE))
    else $error("sequencer started on the first half");

  a_bl32_extend: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    sys_reg.bl32 && sys_lat.lat_ok |-> (sys_lat.off_lat == 6'h08 +
      (sys_reg.wlset ? dtc_pkg::OFF_SET_B[sys_reg.bin] : dtc_pkg::OFF_SET_A[sys_reg.bin])))
    else $error("burst of 32 not extended by eight");

  a_wlvl_strobe: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    (lcfg.wlvl && en && !i_pwr_down) ##0 s_cfg_held ##0 !$past(i_pwr_down)
    |-> (o_dqs_t_term_en && o_dqs_c_term_en))
    else $error("strobes not terminated in leveling");

  a_wlvl_no_dq: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    lcfg.wlvl |=> !o_dq_term_en)
    else $error("data terminated during leveling");

  a_wlvl_off: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    (lcfg.wlvl && !en) ##0 s_cfg_held |-> (!o_dqs_t_term_en && !o_dq_term_en))
    else $error("termination on in disabled leveling");

  a_strength_map: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    (lcfg.term[2:0] == 3'b001) ##0 s_cfg_held |-> (o_term_resistance_ohm == 8'hF0))
    else $error("code 001 not 240 ohms");

  a_pins_equal: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    (o_dq_term_en == o_dmi_term_en) && (o_dqs_t_term_en == o_dqs_c_term_en)
    && (!o_dq_term_en || o_dqs_t_term_en))
    else $error("pins disagree on termination");

  a_disabled_off: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    !en ##0 s_cfg_held |-> (!o_dq_term_en && !o_dqs_t_term_en))
    else $error("termination on while disabled");

  a_wait_before_on: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    s_live_start |=> (!o_dq_term_en)[*3])
    else $error("termination on before latency");

  a_pd_off: assert property (
    @(posedge i_mem_clk) disable iff (link_rst)
    i_pwr_down |=> (!o_dq_term_en && !o_dqs_t_term_en))
    else $error("termination on in power-down");

  a_lat_table: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (sys_reg.bin == 3'h3) && !sys_reg.bl32
    |-> (sys_lat.on_lat == (sys_reg.wlset ? 6'h0C : 6'h04))
        && (sys_lat.off_lat == (sys_reg.wlset ? 6'h1C : 6'h14)))
    else $error("bin 800-1066 latencies wrong");

endmodule
`default_nettype wire

/* File: tb/dtc_mc_model.sv */
`default_nettype none
// ****************************************************************
// Memory controller command model
// ****************************************************************
module dtc_mc_model (
  input  wire logic i_mem_clk,
  output logic      o_wr_cmd,
  output logic      o_cas2_cmd,
  output logic      o_pwr_down
);
  timeunit 1ns;
  timeprecision 100ps;

  // Command bus idle from time zero
  initial begin
    o_wr_cmd   = 1'b0;
    o_cas2_cmd = 1'b0;
    o_pwr_down = 1'b0;
  end

  // First half, optional gap for a slow controller, then second half
  // Returns in the time step of the edge that samples the second half
  task automatic write_cmd(input int gap);
    @(posedge i_mem_clk);
    o_wr_cmd <= 1'b1;
    @(posedge i_mem_clk);
    o_wr_cmd <= 1'b0;
    repeat (gap) @(posedge i_mem_clk);
    o_cas2_cmd <= 1'b1;
    @(posedge i_mem_clk);
    o_cas2_cmd <= 1'b0;
  endtask

  // Power-down level, changed just after an edge
  task automatic set_pd(input logic v);
    @(posedge i_mem_clk);
    o_pwr_down <= v;
  endtask
endmodule
`default_nettype wire

/* File: tb/dtc_top_tb.sv */
`default_nettype none
// ****************************************************************
// Termination control testbench
// ****************************************************************
module dtc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk = 1'b0;  // Register clock, 5 ns
  logic        mem_clk = 1'b0;  // Link clock, 160 ns
  logic        rst = 1'b1;      // Async reset
  logic [7:0]  addr = 8'h00;    // Register address
  logic [31:0] wdata = 32'h0;   // Write data
  logic        wr = 1'b0;       // Write strobe
  logic        rd = 1'b0;       // Read strobe
  logic [31:0] rdata;           // Read data
  logic        wr_cmd;          // First half from model
  logic        cas2;            // Second half from model
  logic        pd;              // Power-down from model
  logic [3:0]  term;            // {dq, dmi, dqs_t, dqs_c}
  logic [7:0]  ohm;             // Selected strength
  logic [31:0] d;               // Scratch read value
  int          n_errors = 0;    // Mismatch count
  int          num_checks = 0;  // Comparison count
  int          cyc = 0;         // Hang guard
  // Ohms per code, zero where no strength exists
  localparam logic [7:0] OHM [0:7] = '{8'h00, 8'hF0, 8'h78, 8'h50,
                                       8'h3C, 8'h30, 8'h28, 8'h00};
  localparam logic [31:0] BIN3 = 32'h0000_00C0;

  always #2.5 sys_clk = ~sys_clk;
  always #80 mem_clk = ~mem_clk;

  dtc_top u_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_mem_clk(mem_clk), .i_wr_cmd(wr_cmd),
    .i_cas2_cmd(cas2), .i_pwr_down(pd), .o_dq_term_en(term[3]),
    .o_dmi_term_en(term[2]), .o_dqs_t_term_en(term[1]), .o_dqs_c_term_en(term[0]),
    .o_term_resistance_ohm(ohm));
  dtc_mc_model u_mc (.i_mem_clk(mem_clk), .o_wr_cmd(wr_cmd), .o_cas2_cmd(cas2),
    .o_pwr_down(pd));

  // Verdict in one place
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Write config, wait for the crossing, let link outputs settle
  task automatic set_cfg(input logic [31:0] v);
    reg_wr(dtc_pkg::CFG_ADDR, v);
    for (int i = 0; i < 200; i++) begin
      reg_rd(dtc_pkg::STAT_ADDR, d);
      if (d[0] === 1'b0) break;
    end
    reg_rd(dtc_pkg::CFG_ADDR, d);
    chk(d, v, "config readback");
    // Step off the edge so pin checks never race the link registers
    repeat (3) @(posedge mem_clk);
    #1;
  endtask

  // One write; all four pins on from edge on_l to edge off_l after E0, idle pattern else
  task automatic burst(input int gap, input int on_l, input int off_l, input logic [3:0] idle);
    u_mc.write_cmd(gap);
    for (int i = 1; i <= off_l + 1; i++) begin
      @(posedge mem_clk);
      #1 chk({28'h0, term}, {28'h0, ((i >= on_l && i < off_l) ? 4'hF : idle)}, "term pins");
    end
  endtask

  initial begin
    repeat (6) @(posedge mem_clk);
    rst <= 1'b0;
    repeat (4) @(posedge mem_clk);
    reg_rd(dtc_pkg::CFG_ADDR, d);
    chk(d, 32'h0, "config reset");
    reg_rd(8'h0C, d);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      set_cfg(32'(c));
      chk({24'h0, ohm}, {24'h0, OHM[c]}, "strength");
    end
    $display("test strength done");
    set_cfg(BIN3 | 32'h2);
    reg_rd(dtc_pkg::LAT_ADDR, d);
    chk(d, 32'h0000_1404, "latency readback");
    burst(0, 4, 20, 4'h0);
    burst(3, 4, 20, 4'h0);
    $display("test burst done");
    set_cfg(BIN3 | 32'h22);
    reg_rd(dtc_pkg::LAT_ADDR, d);
    chk(d, 32'h0000_1C04, "burst32 latency");
    burst(0, 4, 28, 4'h0);
    $display("test burst32 done");
    set_cfg(BIN3 | 32'h202);
    reg_rd(dtc_pkg::LAT_ADDR, d);
    chk(d, 32'h0000_1C0C, "set B latency");
    burst(0, 12, 28, 4'h0);
    $display("test latency set done");
    u_mc.set_pd(1'b1);
    burst(0, 30, 30, 4'h0);
    u_mc.set_pd(1'b0);
    set_cfg(32'h82);
    burst(0, 30, 30, 4'h0);
    set_cfg(BIN3);
    burst(0, 30, 30, 4'h0);
    $display("test refused done");
    set_cfg(BIN3 | 32'h12);
    chk({28'h0, term}, 32'h3, "leveling enabled");
    reg_rd(dtc_pkg::STAT_ADDR, d);
    chk(d, 32'h0000_0014, "leveling status");
    burst(0, 30, 30, 4'h3);
    set_cfg(BIN3 | 32'h10);
    chk({28'h0, term}, 32'h0, "leveling disabled");
    $display("test leveling done");
    summarize();
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
endmodule
`default_nettype wire
